// File: logic/sedc_cfg.svh
// Register offsets, field positions, reset values and timing constants of the capture unit.
`ifndef SEDC_CFG_SVH
`define SEDC_CFG_SVH
`define SEDC_OFF_EV_CTRL 8'h00
`define SEDC_OFF_EV_INTERVAL 8'h04
`define SEDC_OFF_ST_CTRL 8'h08
`define SEDC_OFF_ST_DIV 8'h0c
`define SEDC_OFF_SB_MODE 8'h10
`define SEDC_OFF_SB_RATE_HZ 8'h14
`define SEDC_OFF_SB_DIV 8'h18
`define SEDC_OFF_PRE_MS 8'h1c
`define SEDC_OFF_BLK_SIZE 8'h20
`define SEDC_OFF_BLK_PER_CAP 8'h24
`define SEDC_OFF_TIMESTAMP 8'h28
`define SEDC_OFF_EV_COUNT 8'h2c
`define SEDC_EV_STROBE_SRC 0
`define SEDC_EV_VALUE_CHANGE 1
`define SEDC_EV_FALLING 2
`define SEDC_EV_SAVE_OFFSET 3
`define SEDC_EV_COUNTER_ONLY 4
`define SEDC_ST_FMT_LSB 0
`define SEDC_ST_SAVE 2
`define SEDC_RST_EV_CTRL 32'h0000_0000
`define SEDC_RST_EV_INTERVAL 32'h0000_03e8
`define SEDC_RST_ST_CTRL 32'h0000_0004
`define SEDC_RST_BLK_SIZE 32'h0000_0010
`define SEDC_RST_BLK_PER_CAP 32'h0000_0001
`define SEDC_BLOCK_MIN_HZ 32'h0000_000a
`endif

// File: logic/sedc_pkg.sv
// Types shared by the capture unit: modes, formats and record carriers.
package sedc_pkg;
    typedef enum logic [1:0] {SB_SINGLE, SB_FIXED, SB_STROBE_CTL, SB_CONTINUOUS} sedc_sb_mode_t;
    typedef enum logic [1:0] {FMT_FLOAT32, FMT_FLOAT16, FMT_INTEGER, FMT_MINMAX} sedc_fmt_t;
    typedef struct packed {
        logic valid;
        logic offset;
        logic [7:0] chan;
        logic [31:0] ts;
        logic [31:0] value;
    } sedc_ev_rec_t;
    typedef struct packed {
        logic valid;
        logic store;
        logic [31:0] ts;
        logic [31:0] value;
    } sedc_st_rec_t;
    typedef struct packed {
        logic valid;
        logic first;
        logic [31:0] ts;
        logic [31:0] value;
    } sedc_sb_rec_t;
endpackage

// File: logic/sedc_top.sv
// Event, stream and strobed capture unit with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "sedc_cfg.svh"
module sedc_top #(
    parameter int NCH = 1,
    parameter int DLY_DEPTH = 256,
    parameter int SAMPLES_PER_MS = 25
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Upstream samples and strobe.
    input wire logic sample_valid,
    input wire logic [NCH-1:0][31:0] sample_data,
    input wire logic strobe,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Capture records.
    output sedc_pkg::sedc_ev_rec_t ev_rec,
    output sedc_pkg::sedc_st_rec_t st_rec,
    output sedc_pkg::sedc_sb_rec_t sb_rec
);
    localparam int AW = $clog2(DLY_DEPTH);

    // Parameter values the logic cannot serve are refused.
    if (NCH < 1 || NCH > 256 || DLY_DEPTH < 2 || (DLY_DEPTH & (DLY_DEPTH - 1)) != 0)
    begin : g_bad_param
        $error("sedc_top: NCH must be 1..256 and DLY_DEPTH a power of two");
    end

    // Software registers and bus handshake state.
    logic [31:0] ev_ctrl_q, ev_ctrl_d, ev_int_q, ev_int_d, st_ctrl_q, st_ctrl_d, st_div_q, st_div_d;
    logic [31:0] sb_mode_q, sb_mode_d, sb_hz_q, sb_hz_d, sb_div_q, sb_div_d, pre_ms_q, pre_ms_d;
    logic [31:0] blk_q, blk_d, bpc_q, bpc_d, wdat_q, wdat_d, rdata_q, rdata_d;
    logic [7:0] waddr_q, waddr_d;
    logic awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d, rerr_q, rerr_d, berr_q, berr_d;
    logic [31:0] ts_q, ts_d, evcnt_q, evcnt_d;

    // Byte-lane merge of write data into an old register value.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Register decode and AXI4-Lite handshakes; address and data are taken in either order.
    always_comb
    begin
        {ev_ctrl_d, ev_int_d, st_ctrl_d, st_div_d} = {ev_ctrl_q, ev_int_q, st_ctrl_q, st_div_q};
        {sb_mode_d, sb_hz_d, sb_div_d, pre_ms_d} = {sb_mode_q, sb_hz_q, sb_div_q, pre_ms_q};
        {blk_d, bpc_d, wdat_d, waddr_d, rdata_d} = {blk_q, bpc_q, wdat_q, waddr_q, rdata_q};
        {awr_d, wr_d, bv_d, arr_d, rv_d, rerr_d, berr_d} = {awr_q, wr_q, bv_q, arr_q, rv_q, rerr_q, berr_q};
        if (awr_q && s_axi_awvalid)
        begin
            awr_d = 1'b0;
            waddr_d = s_axi_awaddr;
        end
        if (wr_q && s_axi_wvalid)
        begin
            wr_d = 1'b0;
            wdat_d = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
        end
        // Both halves held and no response pending: perform the write.
        if (!awr_q && !wr_q && !bv_q)
        begin
            bv_d = 1'b1;
            berr_d = 1'b0;
            unique case (waddr_q)
                `SEDC_OFF_EV_CTRL: ev_ctrl_d = merge(ev_ctrl_q, wdat_q, s_axi_wstrb | 4'hf);
                `SEDC_OFF_EV_INTERVAL: ev_int_d = wdat_q;
                `SEDC_OFF_ST_CTRL: st_ctrl_d = wdat_q;
                `SEDC_OFF_ST_DIV: st_div_d = wdat_q;
                `SEDC_OFF_SB_MODE: sb_mode_d = wdat_q;
                `SEDC_OFF_SB_RATE_HZ: sb_hz_d = wdat_q;
                `SEDC_OFF_SB_DIV: sb_div_d = wdat_q;
                `SEDC_OFF_PRE_MS: pre_ms_d = wdat_q;
                `SEDC_OFF_BLK_SIZE: blk_d = wdat_q;
                `SEDC_OFF_BLK_PER_CAP: bpc_d = wdat_q;
                default: berr_d = 1'b1;
            endcase
        end
        if (bv_q && s_axi_bready)
        begin
            {bv_d, awr_d, wr_d} = 3'b011;
        end
        if (arr_q && s_axi_arvalid)
        begin
            arr_d = 1'b0;
            rv_d = 1'b1;
            rerr_d = 1'b0;
            unique case (s_axi_araddr)
                `SEDC_OFF_EV_CTRL: rdata_d = {27'h0, ev_ctrl_q[4:0]};
                `SEDC_OFF_EV_INTERVAL: rdata_d = ev_int_q;
                `SEDC_OFF_ST_CTRL: rdata_d = {29'h0, st_ctrl_q[2:0]};
                `SEDC_OFF_ST_DIV: rdata_d = st_div_q;
                `SEDC_OFF_SB_MODE: rdata_d = {30'h0, sb_mode_q[1:0]};
                `SEDC_OFF_SB_RATE_HZ: rdata_d = sb_hz_q;
                `SEDC_OFF_SB_DIV: rdata_d = sb_div_q;
                `SEDC_OFF_PRE_MS: rdata_d = pre_ms_q;
                `SEDC_OFF_BLK_SIZE: rdata_d = blk_q;
                `SEDC_OFF_BLK_PER_CAP: rdata_d = bpc_q;
                `SEDC_OFF_TIMESTAMP: rdata_d = ts_q;
                `SEDC_OFF_EV_COUNT: rdata_d = evcnt_q;
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rerr_d = 1'b1;
                end
            endcase
        end
        if (rv_q && s_axi_rready)
        begin
            rv_d = 1'b0;
            arr_d = 1'b1;
        end
    end

    // Register stage of the bus slave.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {ev_ctrl_q, ev_int_q, st_ctrl_q} <= {`SEDC_RST_EV_CTRL, `SEDC_RST_EV_INTERVAL, `SEDC_RST_ST_CTRL};
            {st_div_q, sb_mode_q, sb_hz_q, sb_div_q, pre_ms_q} <= '0;
            {blk_q, bpc_q} <= {`SEDC_RST_BLK_SIZE, `SEDC_RST_BLK_PER_CAP};
            {wdat_q, waddr_q, rdata_q} <= '0;
            {awr_q, wr_q, bv_q, arr_q, rv_q, rerr_q, berr_q} <= 7'b1101000;
        end
        else
        begin
            {ev_ctrl_q, ev_int_q, st_ctrl_q, st_div_q} <= {ev_ctrl_d, ev_int_d, st_ctrl_d, st_div_d};
            {sb_mode_q, sb_hz_q, sb_div_q, pre_ms_q} <= {sb_mode_d, sb_hz_d, sb_div_d, pre_ms_d};
            {blk_q, bpc_q, wdat_q, waddr_q, rdata_q} <= {blk_d, bpc_d, wdat_d, waddr_d, rdata_d};
            {awr_q, wr_q, bv_q, arr_q, rv_q, rerr_q, berr_q} <= {awr_d, wr_d, bv_d, arr_d, rv_d, rerr_d, berr_d};
        end
    end

    assign s_axi_awready = awr_q;
    assign s_axi_wready = wr_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = {berr_q, 1'b0};
    assign s_axi_arready = arr_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = {rerr_q, 1'b0};

    // Event capture state.
    logic strb_prev_q, strb_prev_d, walk_q, walk_d, woff_q, woff_d, change;
    logic [31:0] tmr_q, tmr_d, wts_q, wts_d;
    logic [7:0] widx_q, widx_d;
    logic [NCH-1:0][31:0] prev_q, prev_d, snap_q, snap_d;
    sedc_pkg::sedc_ev_rec_t ev_q, ev_d;
    logic pol, pol_prev, onset, offset, trig, cnt_only;

    // Strobe edges against the previous sample; polarity optionally inverted.
    // Combinational edge compare against the registered previous strobe.
    assign pol = strobe ^ ev_ctrl_q[`SEDC_EV_FALLING];
    assign pol_prev = strb_prev_q ^ ev_ctrl_q[`SEDC_EV_FALLING];
    assign onset = sample_valid && pol && !pol_prev;
    assign offset = sample_valid && !pol && pol_prev && ev_ctrl_q[`SEDC_EV_SAVE_OFFSET];
    assign cnt_only = ev_ctrl_q[`SEDC_EV_COUNTER_ONLY] && (NCH == 1);
    assign change = sample_valid && (sample_data != prev_q);

    // Event trigger selection, channel walk and counter.
    always_comb
    begin
        {strb_prev_d, walk_d, woff_d, tmr_d, wts_d} = {strb_prev_q, walk_q, woff_q, tmr_q, wts_q};
        {widx_d, prev_d, snap_d, evcnt_d} = {widx_q, prev_q, snap_q, evcnt_q};
        ev_d = '0;
        trig = 1'b0;
        if (sample_valid)
        begin
            strb_prev_d = strobe;
            prev_d = sample_data;
            tmr_d = (tmr_q + 32'h1 >= ev_int_q) ? 32'h0 : tmr_q + 32'h1;
        end
        if (ev_ctrl_q[`SEDC_EV_VALUE_CHANGE])
        begin
            trig = change;
        end
        else if (ev_ctrl_q[`SEDC_EV_STROBE_SRC])
        begin
            trig = onset || offset;
        end
        else
        begin
            trig = sample_valid && (tmr_q + 32'h1 >= ev_int_q);
        end
        // A trigger arriving during a channel walk is dropped.
        if (walk_q)
        begin
            ev_d = '{1'b1, woff_q, widx_q, wts_q, cnt_only ? evcnt_q : snap_q[widx_q]};
            if (widx_q == 8'(NCH - 1))
            begin
                walk_d = 1'b0;
                if (cnt_only && !woff_q)
                begin
                    evcnt_d = evcnt_q + 32'h1;
                end
            end
            widx_d = widx_q + 8'h1;
        end
        else if (trig)
        begin
            walk_d = 1'b1;
            widx_d = 8'h0;
            woff_d = ev_ctrl_q[`SEDC_EV_STROBE_SRC] && !ev_ctrl_q[`SEDC_EV_VALUE_CHANGE] && offset;
            wts_d = ts_q;
            snap_d = sample_data;
            if (!cnt_only)
            begin
                evcnt_d = evcnt_q + 32'h1;
            end
        end
    end

    // Register stage of event capture and the shared timestamp counter.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {strb_prev_q, walk_q, woff_q, tmr_q, wts_q, widx_q} <= '0;
            {prev_q, snap_q, evcnt_q, ts_q} <= '0;
            ev_q <= '0;
        end
        else
        begin
            {strb_prev_q, walk_q, woff_q, tmr_q, wts_q, widx_q} <= {strb_prev_d, walk_d, woff_d, tmr_d, wts_d, widx_d};
            {prev_q, snap_q, evcnt_q, ts_q} <= {prev_d, snap_d, evcnt_d, ts_d};
            ev_q <= ev_d;
        end
    end

    assign ts_d = sample_valid ? ts_q + 32'h1 : ts_q;
    assign ev_rec = ev_q;

    // Float32 to float16 with truncated mantissa and saturated exponent.
    function automatic logic [15:0] to_half(input logic [31:0] f);
        logic [7:0] e;
        e = f[30:23];
        if (e < 8'd113)
        begin
            return {f[31], 15'h0000};
        end
        if (e > 8'd142)
        begin
            return {f[31], 5'h1f, 10'h000};
        end
        return {f[31], 5'(e - 8'd112), f[22:13]};
    endfunction

    // Stream capture state; channel 0 feeds the stream path.
    logic [31:0] sdiv_q, sdiv_d, mx_q, mx_d, mn_q, mn_d;
    sedc_pkg::sedc_st_rec_t st_q, st_d;
    sedc_pkg::sedc_fmt_t fmt;
    logic s_tick;
    assign fmt = sedc_pkg::sedc_fmt_t'(st_ctrl_q[`SEDC_ST_FMT_LSB +: 2]);
    assign s_tick = sample_valid && (sdiv_q + 32'h1 >= st_div_q);

    // Stream rate division, formatting and min/max tracking.
    always_comb
    begin
        {sdiv_d, mx_d, mn_d} = {sdiv_q, mx_q, mn_q};
        st_d = '0;
        if (sample_valid)
        begin
            sdiv_d = s_tick ? 32'h0 : sdiv_q + 32'h1;
            mx_d = ($signed(sample_data[0]) > $signed(mx_q) || sdiv_q == 32'h0) ? sample_data[0] : mx_q;
            mn_d = ($signed(sample_data[0]) < $signed(mn_q) || sdiv_q == 32'h0) ? sample_data[0] : mn_q;
        end
        if (s_tick)
        begin
            st_d.valid = 1'b1;
            st_d.store = st_ctrl_q[`SEDC_ST_SAVE];
            st_d.ts = ts_q;
            unique case (fmt)
                sedc_pkg::FMT_FLOAT32: st_d.value = sample_data[0];
                sedc_pkg::FMT_FLOAT16: st_d.value = {16'h0000, to_half(sample_data[0])};
                sedc_pkg::FMT_INTEGER: st_d.value = sample_data[0];
                sedc_pkg::FMT_MINMAX: st_d.value = {16'h0000, mx_d[31:24], mn_d[31:24]};
            endcase
        end
    end

    // Register stage of stream capture.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {sdiv_q, mx_q, mn_q} <= '0;
            st_q <= '0;
        end
        else
        begin
            {sdiv_q, mx_q, mn_q} <= {sdiv_d, mx_d, mn_d};
            st_q <= st_d;
        end
    end

    assign st_rec = st_q;

    // Strobed capture: history ring for pre-capture and block sequencing.
    logic [31:0] ring [DLY_DEPTH];
    logic [AW-1:0] wp_q, wp_d, pre;
    logic [31:0] cdiv_q, cdiv_d, pos_q, pos_d, left_q, left_d, pre_prod, pick;
    logic sprev_q, sprev_d, rise, c_tick, block, run;
    sedc_pkg::sedc_sb_rec_t sb_q, sb_d;
    sedc_pkg::sedc_sb_mode_t mode;

    assign mode = sedc_pkg::sedc_sb_mode_t'(sb_mode_q[1:0]);
    // Delay clamped to one less than the ring depth.
    assign pre_prod = 32'(pre_ms_q * 32'(SAMPLES_PER_MS));
    assign pre = (pre_prod > 32'(DLY_DEPTH - 1)) ? AW'(DLY_DEPTH - 1) : pre_prod[AW-1:0];
    // The ring slot at the write pointer is only filled at this edge, so a zero delay takes the live sample instead.
    assign pick = (pre == '0) ? sample_data[0] : ring[wp_q - pre];
    assign rise = sample_valid && strobe && !sprev_q;
    assign c_tick = sample_valid && (cdiv_q + 32'h1 >= sb_div_q);
    assign block = sb_hz_q >= `SEDC_BLOCK_MIN_HZ;

    // Decide whether this capture tick records.
    always_comb
    begin
        run = 1'b0;
        unique case (mode)
            sedc_pkg::SB_SINGLE: run = 1'b0;
            sedc_pkg::SB_FIXED: run = left_q != 32'h0;
            sedc_pkg::SB_STROBE_CTL: run = strobe || (block && pos_q != 32'h0);
            sedc_pkg::SB_CONTINUOUS: run = 1'b1;
        endcase
    end

    // Strobed capture sequencing.
    always_comb
    begin
        {wp_d, cdiv_d, pos_d, left_d, sprev_d} = {wp_q, cdiv_q, pos_q, left_q, sprev_q};
        sb_d = '0;
        if (sample_valid)
        begin
            wp_d = wp_q + AW'(1);
            sprev_d = strobe;
            cdiv_d = c_tick ? 32'h0 : cdiv_q + 32'h1;
        end
        if (mode == sedc_pkg::SB_SINGLE && rise)
        begin
            sb_d = '{1'b1, 1'b1, ts_q - 32'(pre), pick};
        end
        else if (mode == sedc_pkg::SB_FIXED && rise && left_q == 32'h0)
        begin
            left_d = 32'(blk_q * (block ? bpc_q : 32'h1));
            pos_d = 32'h0;
            cdiv_d = 32'h0;
        end
        else if (c_tick && run)
        begin
            sb_d = '{1'b1, !block || pos_q == 32'h0, ts_q - 32'(pre), pick};
            pos_d = (!block || pos_q + 32'h1 >= blk_q) ? 32'h0 : pos_q + 32'h1;
            if (left_q != 32'h0)
            begin
                left_d = left_q - 32'h1;
            end
        end
        if (mode != sedc_pkg::SB_FIXED)
        begin
            left_d = 32'h0;
        end
    end

    // History ring write; holds sample history only, so no reset is needed.
    always_ff @(posedge clk)
    begin
        if (sample_valid)
        begin
            ring[wp_q] <= sample_data[0];
        end
    end

    // Register stage of strobed capture.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {wp_q, cdiv_q, pos_q, left_q, sprev_q} <= '0;
            sb_q <= '0;
        end
        else
        begin
            {wp_q, cdiv_q, pos_q, left_q, sprev_q} <= {wp_d, cdiv_d, pos_d, left_d, sprev_d};
            sb_q <= sb_d;
        end
    end

    assign sb_rec = sb_q;
endmodule

// File: test/sedc_checker.sv
// Port-level assertions for the capture unit.
`timescale 1ns/1ps
module sedc_checker #(
    parameter int NCH = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Upstream tick.
    input wire logic sample_valid,
    // Register bus.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    // Records.
    input wire sedc_pkg::sedc_ev_rec_t ev_rec,
    input wire sedc_pkg::sedc_st_rec_t st_rec,
    input wire sedc_pkg::sedc_sb_rec_t sb_rec
);
    logic seen_q;
    logic [31:0] last_ts_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Remembers whether and with which timestamp a stream point was seen.
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            seen_q <= 1'b0;
        else if (st_rec.valid)
            seen_q <= 1'b1;
    // Last stream timestamp; needs no reset because seen_q guards it.
    always_ff @(posedge clk)
        if (st_rec.valid)
            last_ts_q <= st_rec.ts;
    sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    property p_rd_answer; s_rd_take |-> ##[1:2] s_axi_rvalid; endproperty
    property p_wr_answer; s_wr_take |-> ##[1:3] s_axi_bvalid; endproperty
    property p_unmapped;
        s_rd_take ##0 (s_axi_araddr > 8'h2c) |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == '0);
    endproperty
    property p_aw_blocked; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_st_tick; st_rec.valid |-> $past(sample_valid); endproperty
    property p_sb_tick; sb_rec.valid |-> $past(sample_valid); endproperty
    property p_chan_walk; ev_rec.valid && ev_rec.chan == 8'h00 && NCH > 1 |=> ev_rec.valid && ev_rec.chan == 8'h01;
    endproperty
    property p_chan_ts; ev_rec.valid && ev_rec.chan != 8'h00 |-> $past(ev_rec.valid) && ev_rec.ts == $past(ev_rec.ts);
    endproperty
    property p_ts_rise; st_rec.valid && seen_q |-> st_rec.ts > last_ts_q; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    a_aw_blocked: assert property (p_aw_blocked) else $error("write taken while answer pending");
    a_st_tick: assert property (p_st_tick) else $error("stream point without tick");
    a_sb_tick: assert property (p_sb_tick) else $error("strobed point without tick");
    a_chan_walk: assert property (p_chan_walk) else $error("channel walk broken");
    a_chan_ts: assert property (p_chan_ts) else $error("extra channel timestamp differs");
    a_ts_rise: assert property (p_ts_rise) else $error("timestamp not rising");
endmodule
bind sedc_top sedc_checker #(.NCH(NCH)) u_checker (.clk(clk), .rst_b(rst_b), .sample_valid(sample_valid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .ev_rec(ev_rec), .st_rec(st_rec), .sb_rec(sb_rec));

// File: test/sedc_upstream_model.sv
// Upstream source model: one sample tick every other cycle, strobe and data levels.
`timescale 1ns/1ps
module sedc_upstream_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Levels asked for by the bench.
    input wire logic [63:0] data_in,
    input wire logic strobe_in,
    // Toward the capture unit.
    output logic sample_valid,
    output logic [63:0] sample_data,
    output logic strobe
);
    logic ph_q;
    // Tick phase toggles each cycle.
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            ph_q <= 1'b0;
        else
            ph_q <= !ph_q;
    // Between ticks the data word is not valid, so it shows the inverse.
    assign sample_valid = ph_q;
    assign sample_data = ph_q ? data_in : ~data_in;
    assign strobe = strobe_in;
endmodule

// File: test/sedc_top_tb.sv
// Self-checking bench for the capture unit.
`timescale 1ns/1ps
`include "sedc_cfg.svh"
module sedc_top_tb;
    logic clk = 0, rst_b = 0, strb = 0, awv = 0, wv = 0, arv = 0, sv, stb, awr, wr_r, bv, arr, rv;
    logic [7:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat, rd_v, ev_dt, ev_ts, ev_v0, ev_v1, st_v, sb_v;
    logic [1:0] br, rr, rd_r, wr_b;
    logic [63:0] din = '0, sd;
    logic [15:0] rnd = 16'ha0a7;
    logic st_sv;
    sedc_pkg::sedc_ev_rec_t ev;
    sedc_pkg::sedc_st_rec_t st;
    sedc_pkg::sedc_sb_rec_t sb;
    int n_errors = 0, checks = 0, n_ev = 0, n_off = 0, n_st = 0, n_sb = 0, n_fst = 0, e, f;
    sedc_upstream_model src (.clk(clk), .rst_b(rst_b), .data_in(din), .strobe_in(strb), .sample_valid(sv),
        .sample_data(sd), .strobe(stb));
    sedc_top #(.NCH(2)) uut (.clk(clk), .rst_b(rst_b), .sample_valid(sv), .sample_data(sd), .strobe(stb),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(1'b1), .ev_rec(ev), .st_rec(st), .sb_rec(sb));
    // Free-running 200 MHz clock.
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic int fixed_total(input int bs, input int bpc, input bit blk);
        return blk ? bs * bpc : bs;
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awr)
                awv <= 1'b0;
            if (wr_r)
                wv <= 1'b0;
        end
        while (awv || wv);
        do
            @(posedge clk);
        while (bv !== 1'b1);
        wr_b = br;
    endtask
    task rd(input logic [7:0] a);
        ara <= a;
        arv <= 1'b1;
        do
            @(posedge clk);
        while (arr !== 1'b1);
        arv <= 1'b0;
        do
            @(posedge clk);
        while (rv !== 1'b1);
        rd_v = rdat;
        rd_r = rr;
    endtask
    task wait_smp(input int n);
        repeat (n) @(posedge clk iff sv);
    endtask
    task pulse;
        strb <= 1'b1;
        wait_smp(2);
        strb <= 1'b0;
        wait_smp(14);
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Collects records at the falling edge, where they are settled.
    always @(negedge clk)
    begin
        if (ev.valid === 1'b1)
        begin
            n_ev++;
            n_off += int'(ev.offset);
            if (ev.chan == 8'h00)
            begin
                ev_dt = ev.ts - ev_ts;
                ev_ts = ev.ts;
                ev_v0 = ev.value;
            end
            else
                ev_v1 = ev.value;
        end
        if (st.valid === 1'b1)
        begin
            n_st++;
            st_v = st.value;
            st_sv = st.store;
        end
        if (sb.valid === 1'b1)
        begin
            n_sb++;
            n_fst += int'(sb.first);
            sb_v = sb.value;
        end
    end
    // Cuts a hang short.
    initial
    begin
        #100us;
        n_errors++;
        report_and_stop;
    end
    // Main sequence: registers, event, stream and strobed capture.
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(`SEDC_OFF_EV_CTRL); chk(rd_v, `SEDC_RST_EV_CTRL);
        rd(`SEDC_OFF_EV_INTERVAL); chk(rd_v, `SEDC_RST_EV_INTERVAL);
        rd(`SEDC_OFF_ST_CTRL); chk(rd_v, `SEDC_RST_ST_CTRL);
        rd(`SEDC_OFF_BLK_SIZE); chk(rd_v, `SEDC_RST_BLK_SIZE);
        rd(`SEDC_OFF_BLK_PER_CAP); chk(rd_v, `SEDC_RST_BLK_PER_CAP);
        rd(8'h30); chk(rd_r, 2'b10); chk(rd_v, 32'h0);
        wr(8'h30, 32'h0); chk(wr_b, 2'b10);
        wr(`SEDC_OFF_EV_INTERVAL, 32'h4); wait_smp(20); chk(ev_dt, 32'h4);
        wr(`SEDC_OFF_EV_CTRL, 32'h2); wait_smp(4); e = n_ev; rnd = lfsr(rnd);
        din[63:32] <= {rnd, rnd}; wait_smp(6); chk(n_ev - e, 2); chk(ev_v1, {rnd, rnd});
        wr(`SEDC_OFF_EV_CTRL, 32'h5); e = n_ev; strb <= 1'b1; wait_smp(6); chk(n_ev - e, 0);
        strb <= 1'b0; wait_smp(6); chk(n_ev - e, 2);
        wr(`SEDC_OFF_EV_CTRL, 32'h9); e = n_ev; strb <= 1'b1; wait_smp(6); chk(n_ev - e, 2);
        strb <= 1'b0; wait_smp(6); chk(n_off > 0, 1);
        wr(`SEDC_OFF_EV_CTRL, 32'h11); din[31:0] <= {rnd, 16'h5a3c}; pulse; chk(ev_v0, {rnd, 16'h5a3c});
        wr(`SEDC_OFF_ST_CTRL, 32'h2); wait_smp(2); e = n_st; wait_smp(10); chk(n_st - e, 10);
        chk(st_v, din[31:0]); chk(st_sv, 1'b0);
        wr(`SEDC_OFF_SB_DIV, 32'h1); wr(`SEDC_OFF_SB_RATE_HZ, 32'h1); wr(`SEDC_OFF_SB_MODE, 32'h3);
        wait_smp(2); e = n_sb; f = n_fst; wait_smp(10); chk(n_sb - e, 10); chk(n_fst - f, 10);
        wr(`SEDC_OFF_SB_MODE, 32'h1); wr(`SEDC_OFF_SB_RATE_HZ, 32'h64);
        wr(`SEDC_OFF_BLK_SIZE, 32'h4); wr(`SEDC_OFF_BLK_PER_CAP, 32'h2);
        e = n_sb; f = n_fst; pulse; chk(n_sb - e, fixed_total(4, 2, 1)); chk(n_fst - f, 2);
        wr(`SEDC_OFF_SB_MODE, 32'h0); wr(`SEDC_OFF_SB_RATE_HZ, 32'h1);
        e = n_sb; pulse; chk(n_sb - e, 1); chk(sb_v, din[31:0]);
        report_and_stop;
    end
endmodule
